// File: hdl/tbt_timer_top.sv
// Timebase timer unit: tick counter, countdown timer, interval timer, watchdog
// Assumes a simple strobed register port and ext_tick_in synchronous to sys_clk_in
//
// How it works
// - A 64-bit tick counter adds one per tick from the core clock or the external tick.
// - All three timers advance only on the tick counter's increment pulse.
// - The 32-bit countdown register is software loaded and drops by one per tick.
// - Without auto-reload the countdown stops at zero, holds it and raises its interrupt.
// - With auto-reload it raises the interrupt, loads the reload register and keeps going.
// - Software picks one of four tick bits for the interval timer.
// - The interval event fires only on a 0 to 1 change of the chosen bit.
// - The watchdog raises a critical interrupt at every interval end.
// - Software picks one of four watchdog intervals and the reset type requested.
// - An enabled watchdog requests reset after two intervals with no software service.
// - Debug halt with freeze stops the tick counter and all timers.
//
// The register offsets and the plain strobed port are this design's own decisions.
`include "tbt_map.svh"
`default_nettype none
module tbt_timer_top (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic ext_tick_in,
  input wire logic debug_halt_in,
  input wire logic freeze_req_in,
  input wire logic [7:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [31:0] rdata_out,
  output logic irq_out,
  output logic crit_irq_out,
  output logic [1:0] reset_type_out,
  output logic reset_req_out
);
  logic [63:0] tick_ff;
  logic [31:0] countdown_ff;
  logic [31:0] reload_ff;
  logic [31:0] ctrl_ff;
  logic [3:0] status_ff;
  logic [3:0] mask_ff;
  logic ext_prev_ff;
  logic [31:0] rdata_ff;
  logic reset_req_ff;
  tbt_pkg::tbt_wd_state_t wd_state_ff;
  tbt_pkg::tbt_wd_state_t nxt_wd_state;

  logic frozen;
  logic ext_rise;
  logic tick;
  logic wr_tick_lo;
  logic wr_tick_hi;
  logic wr_countdown;
  logic wr_reload;
  logic wr_ctrl;
  logic wr_status;
  logic wr_mask;
  logic cd_zero;
  logic cd_event;
  logic [31:0] nxt_countdown;
  logic pit_event;
  logic wd_event;
  logic wd_service;
  logic [3:0] set_bits;
  logic [3:0] nxt_status;
  logic [31:0] nxt_rdata;

  // ----------------------------------------
  // Register decode
  // ----------------------------------------
  assign wr_tick_lo = wr_in && (addr_in == `TBT_ADDR_TICK_LO);
  assign wr_tick_hi = wr_in && (addr_in == `TBT_ADDR_TICK_HI);
  assign wr_countdown = wr_in && (addr_in == `TBT_ADDR_COUNTDOWN);
  assign wr_reload = wr_in && (addr_in == `TBT_ADDR_RELOAD);
  assign wr_ctrl = wr_in && (addr_in == `TBT_ADDR_CTRL);
  assign wr_status = wr_in && (addr_in == `TBT_ADDR_STATUS);
  assign wr_mask = wr_in && (addr_in == `TBT_ADDR_MASK);

  // ----------------------------------------
  // Tick source and freeze
  // ----------------------------------------
  assign frozen = debug_halt_in && freeze_req_in;
  assign ext_rise = ext_tick_in && !ext_prev_ff;
  assign tick = !frozen && (ctrl_ff[`TBT_CTRL_EXT_TICK] ? ext_rise : 1'b1);

  // External tick edge history
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      ext_prev_ff <= 1'b0;
    end else begin
      ext_prev_ff <= ext_tick_in;
    end
  end

  // Free-running tick counter, software may load either half
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      tick_ff <= 64'h0;
    end else if (wr_tick_lo) begin
      tick_ff <= {tick_ff[63:32], wdata_in};
    end else if (wr_tick_hi) begin
      tick_ff <= {wdata_in, tick_ff[31:0]};
    end else if (tick) begin
      tick_ff <= tick_ff + 64'h1;
    end
  end

  // ----------------------------------------
  // Countdown timer
  // ----------------------------------------
  assign cd_zero = (countdown_ff == 32'h0);
  assign cd_event = tick && (countdown_ff == 32'h1);
  always_comb begin
    nxt_countdown = countdown_ff;
    if (wr_countdown) begin
      nxt_countdown = wdata_in;
    end else if (cd_event && ctrl_ff[`TBT_CTRL_AUTO_RELOAD]) begin
      nxt_countdown = reload_ff;
    end else if (tick && !cd_zero) begin
      nxt_countdown = countdown_ff - 32'h1;
    end
  end

  // Countdown and reload registers
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      countdown_ff <= 32'h0;
      reload_ff <= 32'h0;
    end else begin
      countdown_ff <= nxt_countdown;
      reload_ff <= wr_reload ? wdata_in : reload_ff;
    end
  end

  // ----------------------------------------
  // Interval timer and watchdog taps
  // ----------------------------------------
  tbt_edge_tap #(
    .TAP0(`TBT_PIT_TAP0),
    .TAP1(`TBT_PIT_TAP1),
    .TAP2(`TBT_PIT_TAP2),
    .TAP3(`TBT_PIT_TAP3)
  ) u_pit_tap (
    .sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b_in),
    .count_in(tick_ff),
    .sel_in(ctrl_ff[`TBT_CTRL_PIT_SEL_LO +: 2]),
    .rise_out(pit_event)
  );

  tbt_edge_tap #(
    .TAP0(`TBT_WD_TAP0),
    .TAP1(`TBT_WD_TAP1),
    .TAP2(`TBT_WD_TAP2),
    .TAP3(`TBT_WD_TAP3)
  ) u_wd_tap (
    .sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b_in),
    .count_in(tick_ff),
    .sel_in(ctrl_ff[`TBT_CTRL_WD_SEL_LO +: 2]),
    .rise_out(wd_event)
  );

  // ----------------------------------------
  // Watchdog state
  // ----------------------------------------
  assign wd_service = wr_status && wdata_in[`TBT_ST_WD];
  always_comb begin
    nxt_wd_state = wd_state_ff;
    unique case (wd_state_ff)
      tbt_pkg::TBT_WD_IDLE: begin
        if (wd_event) begin
          nxt_wd_state = tbt_pkg::TBT_WD_ARMED;
        end
      end
      tbt_pkg::TBT_WD_ARMED: begin
        if (wd_event && ctrl_ff[`TBT_CTRL_WD_EN]) begin
          nxt_wd_state = tbt_pkg::TBT_WD_FIRED;
        end else if (wd_service) begin
          nxt_wd_state = tbt_pkg::TBT_WD_IDLE;
        end
      end
      tbt_pkg::TBT_WD_FIRED: begin
        nxt_wd_state = tbt_pkg::TBT_WD_FIRED;
      end
      default: begin
        nxt_wd_state = tbt_pkg::TBT_WD_IDLE;
      end
    endcase
  end

  // Watchdog state and sticky reset request
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      wd_state_ff <= tbt_pkg::TBT_WD_IDLE;
      reset_req_ff <= 1'b0;
    end else begin
      wd_state_ff <= nxt_wd_state;
      reset_req_ff <= (nxt_wd_state == tbt_pkg::TBT_WD_FIRED);
    end
  end

  // ----------------------------------------
  // Status, mask, interrupts
  // ----------------------------------------
  assign set_bits = {1'b0, wd_event, pit_event, cd_event};
  assign nxt_status = (status_ff & ~(wr_status ? wdata_in[3:0] : 4'h0)) | set_bits;

  // Sticky status, set wins over clear
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      status_ff <= 4'h0;
      mask_ff <= 4'h0;
      ctrl_ff <= `TBT_CTRL_RESET;
    end else begin
      status_ff <= nxt_status;
      mask_ff <= wr_mask ? wdata_in[3:0] : mask_ff;
      ctrl_ff <= wr_ctrl ? wdata_in : ctrl_ff;
    end
  end

  assign irq_out = |(status_ff[1:0] & mask_ff[1:0]);
  assign crit_irq_out = status_ff[`TBT_ST_WD] & mask_ff[`TBT_ST_WD];
  assign reset_type_out = ctrl_ff[`TBT_CTRL_WD_RST_LO +: 2];
  assign reset_req_out = reset_req_ff;

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  always_comb begin
    nxt_rdata = 32'h0;
    if (rd_in) begin
      unique case (addr_in)
        `TBT_ADDR_TICK_LO: nxt_rdata = tick_ff[31:0];
        `TBT_ADDR_TICK_HI: nxt_rdata = tick_ff[63:32];
        `TBT_ADDR_COUNTDOWN: nxt_rdata = countdown_ff;
        `TBT_ADDR_RELOAD: nxt_rdata = reload_ff;
        `TBT_ADDR_CTRL: nxt_rdata = ctrl_ff;
        `TBT_ADDR_STATUS: nxt_rdata = {28'h0, status_ff};
        `TBT_ADDR_MASK: nxt_rdata = {28'h0, mask_ff};
        default: nxt_rdata = 32'h0;
      endcase
    end
  end

  // Read data one cycle after the strobe
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      rdata_ff <= 32'h0;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end
  assign rdata_out = rdata_ff;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_armed;
    wd_state_ff == tbt_pkg::TBT_WD_ARMED;
  endsequence
  sequence s_second_end;
    wd_event && ctrl_ff[`TBT_CTRL_WD_EN] && !rd_in;
  endsequence

  AST_TICK_INC: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    (tick && !wr_tick_lo && !wr_tick_hi) |=> tick_ff == $past(tick_ff) + 64'h1)
    else $error("tick counter did not advance");
  AST_NO_TICK_HOLD: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    (!tick && !wr_in) |=> $stable(tick_ff) && $stable(countdown_ff))
    else $error("timer moved without a tick");
  AST_CD_DEC: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    (tick && !wr_in && countdown_ff > 32'h1) |=> countdown_ff == $past(countdown_ff) - 32'h1)
    else $error("countdown did not decrement");
  AST_CD_HOLD0: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    (cd_zero && !wr_countdown) |=> cd_zero)
    else $error("countdown left zero by itself");
  AST_CD_RELOAD: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    (cd_event && ctrl_ff[1] && !wr_countdown) |=> countdown_ff == $past(reload_ff)
      && status_ff[0])
    else $error("auto-reload failed");
  AST_FREEZE: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    frozen |-> !tick)
    else $error("tick during freeze");
  AST_WD_RESET: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    s_armed ##0 s_second_end |=> reset_req_out)
    else $error("watchdog did not request reset");
  AST_WD_FIRST: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    (wd_state_ff == tbt_pkg::TBT_WD_IDLE && wd_event) |=> s_armed ##0 status_ff[2]
      ##0 !reset_req_out)
    else $error("first watchdog end mishandled");
  AST_IRQ_STICKY: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    (status_ff[0] && !(wr_status && wdata_in[0])) |=> status_ff[0])
    else $error("pending flag dropped without clear");
endmodule : tbt_timer_top
`default_nettype wire

// File: hdl/tbt_map.svh
// Register offsets, field positions and reset values of the timebase timer unit
// Assumes word-wide software port with byte addresses
`ifndef TBT_MAP_SVH
`define TBT_MAP_SVH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define TBT_ADDR_TICK_LO 8'h00
`define TBT_ADDR_TICK_HI 8'h04
`define TBT_ADDR_COUNTDOWN 8'h08
`define TBT_ADDR_RELOAD 8'h0c
`define TBT_ADDR_CTRL 8'h10
`define TBT_ADDR_STATUS 8'h14
`define TBT_ADDR_MASK 8'h18
// ----------------------------------------
// Control fields
// ----------------------------------------
`define TBT_CTRL_EXT_TICK 0
`define TBT_CTRL_AUTO_RELOAD 1
`define TBT_CTRL_PIT_SEL_LO 2
`define TBT_CTRL_WD_SEL_LO 4
`define TBT_CTRL_WD_RST_LO 6
`define TBT_CTRL_WD_EN 8
`define TBT_CTRL_RESET 32'h0000_0000
// ----------------------------------------
// Status and mask bits
// ----------------------------------------
`define TBT_ST_COUNTDOWN 0
`define TBT_ST_PIT 1
`define TBT_ST_WD 2
`define TBT_ST_W 3
// ----------------------------------------
// Tick counter taps
// ----------------------------------------
`define TBT_PIT_TAP0 9
`define TBT_PIT_TAP1 13
`define TBT_PIT_TAP2 17
`define TBT_PIT_TAP3 21
`define TBT_WD_TAP0 17
`define TBT_WD_TAP1 21
`define TBT_WD_TAP2 25
`define TBT_WD_TAP3 29
`endif

// File: hdl/tbt_pkg.sv
// Types shared by the timebase timer unit
// Assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package tbt_pkg;
  // Watchdog expiry progress
  typedef enum logic [1:0] {
    TBT_WD_IDLE,
    TBT_WD_ARMED,
    TBT_WD_FIRED
  } tbt_wd_state_t;
endpackage : tbt_pkg
`default_nettype wire

// File: hdl/tbt_edge_tap.sv
// Rising-edge detector on one of four tick-counter taps
// Assumes the tick counter from the timer top
`include "tbt_map.svh"
`default_nettype none
module tbt_edge_tap #(
  parameter int TAP0 = 0,
  parameter int TAP1 = 1,
  parameter int TAP2 = 2,
  parameter int TAP3 = 3
) (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic [63:0] count_in,
  input wire logic [1:0] sel_in,
  output logic rise_out
);
  logic [3:0] taps;
  logic cur;
  logic prev_ff;

  // ----------------------------------------
  // Tap selection
  // ----------------------------------------
  assign taps = {count_in[TAP3], count_in[TAP2], count_in[TAP1], count_in[TAP0]};
  assign cur = taps[sel_in];

  // Previous value of the selected bit
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      prev_ff <= 1'b0;
    end else begin
      prev_ff <= cur;
    end
  end

  // Only 0 to 1 counts
  assign rise_out = cur & ~prev_ff;

  AST_RISE_ONLY: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    rise_out |-> (cur && !$past(cur)))
    else $error("tap event without a rising edge");
  AST_NO_FALL: assert property (@(posedge sys_clk_in) disable iff (!rst_b_in)
    (!cur && prev_ff) |-> !rise_out)
    else $error("tap event on a falling edge");
endmodule : tbt_edge_tap
`default_nettype wire

// File: dv/timebase_timer_unit_test.sv
// Self-checking bench for the timebase timer unit, driving its ports directly
// Assumes the register map header and the timer top compiled before it
`include "tbt_map.svh"
`default_nettype none
module timebase_timer_unit_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic ext_tick_in = 1'b0;
  logic debug_halt_in = 1'b0;
  logic freeze_req_in = 1'b0;
  logic [7:0] addr_in = 8'h00;
  logic [31:0] wdata_in = 32'h0000_0000;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [31:0] rdata_out;
  logic irq_out;
  logic crit_irq_out;
  logic [1:0] reset_type_out;
  logic reset_req_out;
  wire [2:0] outs = {reset_req_out, crit_irq_out, irq_out};
  int fails = 0;
  int checks = 0;
  int cyc_n = 0;
  logic [31:0] a;
  logic [31:0] b;
  int n;
  int r;
  int k;
  int t0;
  logic [1:0] rt;
  logic [7:0] zero_regs [6] = '{`TBT_ADDR_COUNTDOWN, `TBT_ADDR_RELOAD, `TBT_ADDR_CTRL,
                                 `TBT_ADDR_STATUS, `TBT_ADDR_MASK, 8'h1c};

  // ----------------------------------------
  // Clock, cycle count, design
  // ----------------------------------------
  always #20 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in) cyc_n++;

  tbt_timer_top DUT (
    .sys_clk_in(sys_clk_in),
    .rst_b_in(rst_b_in),
    .ext_tick_in(ext_tick_in),
    .debug_halt_in(debug_halt_in),
    .freeze_req_in(freeze_req_in),
    .addr_in(addr_in),
    .wdata_in(wdata_in),
    .wr_in(wr_in),
    .rd_in(rd_in),
    .rdata_out(rdata_out),
    .irq_out(irq_out),
    .crit_irq_out(crit_irq_out),
    .reset_type_out(reset_type_out),
    .reset_req_out(reset_req_out)
  );

  // ----------------------------------------
  // Bus cycles and comparison
  // ----------------------------------------
  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge sys_clk_in);
    addr_in <= ad;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge sys_clk_in);
    wr_in <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] ad, output logic [31:0] d);
    @(posedge sys_clk_in);
    addr_in <= ad;
    rd_in <= 1'b1;
    @(posedge sys_clk_in);
    rd_in <= 1'b0;
    #1;
    d = rdata_out;
  endtask : rd

  // Bounded wait for one output, cycles spent in cnt
  task automatic wait_out(input int w, input int lim, output int cnt);
    cnt = 0;
    while (outs[w] !== 1'b1 && cnt < lim) begin
      @(posedge sys_clk_in);
      #1;
      cnt++;
    end
  endtask : wait_out

  task automatic summarize;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : summarize

  // ----------------------------------------
  // Hang guard
  // ----------------------------------------
  initial begin
    #(40 * 80000);
    fails++;
    summarize();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    void'($urandom(32'h9a67113a));
    repeat (6) @(posedge sys_clk_in);
    rst_b_in <= 1'b1;
    foreach (zero_regs[i]) begin
      rd(zero_regs[i], a);
      chk("reset reg", a, 0);
    end
    $display("test reset done");
    // Core clock ticks, then external ticks
    rd(`TBT_ADDR_TICK_LO, a);
    rd(`TBT_ADDR_TICK_LO, b);
    chk("tick step", b - a, 2);
    wr(`TBT_ADDR_CTRL, 32'h0000_0001);
    rd(`TBT_ADDR_TICK_LO, a);
    repeat (5) begin
      @(posedge sys_clk_in);
      ext_tick_in <= 1'b1;
      @(posedge sys_clk_in);
      ext_tick_in <= 1'b0;
    end
    rd(`TBT_ADDR_TICK_LO, b);
    chk("ext ticks", b - a, 5);
    wr(`TBT_ADDR_CTRL, 32'h0000_0000);
    // Freeze needs halt and command together
    @(posedge sys_clk_in);
    debug_halt_in <= 1'b1;
    freeze_req_in <= 1'b1;
    rd(`TBT_ADDR_TICK_LO, a);
    repeat (10) @(posedge sys_clk_in);
    rd(`TBT_ADDR_TICK_LO, b);
    chk("frozen", b, a);
    @(posedge sys_clk_in);
    freeze_req_in <= 1'b0;
    rd(`TBT_ADDR_TICK_LO, a);
    rd(`TBT_ADDR_TICK_LO, b);
    chk("halt only", b - a, 2);
    @(posedge sys_clk_in);
    debug_halt_in <= 1'b0;
    $display("test tick done");
    // One-shot countdown, hold at zero, mask and clear
    wr(`TBT_ADDR_MASK, 32'h0000_0001);
    wr(`TBT_ADDR_STATUS, 32'h0000_0007);
    n = 5 + $urandom % 20;
    wr(`TBT_ADDR_COUNTDOWN, n);
    wait_out(0, n + 10, k);
    chk("cd delay", k, n);
    rd(`TBT_ADDR_COUNTDOWN, a);
    chk("cd zero", a, 0);
    repeat (5) @(posedge sys_clk_in);
    rd(`TBT_ADDR_COUNTDOWN, a);
    chk("cd hold", a, 0);
    wr(`TBT_ADDR_MASK, 32'h0000_0000);
    chk("masked irq", irq_out, 0);
    rd(`TBT_ADDR_STATUS, a);
    chk("cd pending", a[`TBT_ST_COUNTDOWN], 1);
    wr(`TBT_ADDR_MASK, 32'h0000_0001);
    chk("unmasked irq", irq_out, 1);
    wr(`TBT_ADDR_STATUS, 32'h0000_0001);
    chk("cleared irq", irq_out, 0);
    $display("test countdown done");
    // Auto-reload fires again after the reload span
    r = 10 + $urandom % 50;
    wr(`TBT_ADDR_RELOAD, r);
    wr(`TBT_ADDR_CTRL, 32'h0000_0002);
    wr(`TBT_ADDR_COUNTDOWN, 3);
    wait_out(0, 12, k);
    wr(`TBT_ADDR_STATUS, 32'h0000_0001);
    rd(`TBT_ADDR_COUNTDOWN, a);
    chk("reloaded", (a <= r) && (a > r - 12), 1);
    wait_out(0, r + 4, k);
    chk("refire", irq_out, 1);
    $display("test reload done");
    // Interval timer: period of rising edges on two taps
    wr(`TBT_ADDR_MASK, 32'h0000_0002);
    for (int s = 0; s < 2; s++) begin
      wr(`TBT_ADDR_CTRL, s << `TBT_CTRL_PIT_SEL_LO);
      wr(`TBT_ADDR_STATUS, 32'h0000_0007);
      wait_out(0, 40000, k);
      t0 = cyc_n;
      wr(`TBT_ADDR_STATUS, 32'h0000_0002);
      wait_out(0, 40000, k);
      chk("pit period", cyc_n - t0, 2 ** ((s == 0 ? `TBT_PIT_TAP0 : `TBT_PIT_TAP1) + 1));
    end
    $display("test interval done");
    // Watchdog: serviced once, then left to expire
    rt = $urandom % 4;
    wr(`TBT_ADDR_MASK, 32'h0000_0004);
    wr(`TBT_ADDR_CTRL, 32'h0000_0100 | (rt << `TBT_CTRL_WD_RST_LO));
    wr(`TBT_ADDR_STATUS, 32'h0000_0007);
    wr(`TBT_ADDR_TICK_LO, 32'h0001_fff0);
    wait_out(1, 60, k);
    chk("wd crit", crit_irq_out, 1);
    chk("wd first", reset_req_out, 0);
    wr(`TBT_ADDR_STATUS, 32'h0000_0004);
    chk("wd cleared", crit_irq_out, 0);
    wr(`TBT_ADDR_TICK_LO, 32'h0001_fff0);
    wait_out(1, 60, k);
    repeat (3) @(posedge sys_clk_in);
    chk("wd serviced", reset_req_out, 0);
    wr(`TBT_ADDR_TICK_LO, 32'h0001_fff0);
    wait_out(2, 60, k);
    chk("wd expire", reset_req_out, 1);
    chk("wd type", reset_type_out, rt);
    @(posedge sys_clk_in);
    rst_b_in <= 1'b0;
    repeat (3) @(posedge sys_clk_in);
    rst_b_in <= 1'b1;
    @(posedge sys_clk_in);
    #1;
    chk("req cleared", reset_req_out, 0);
    $display("test watchdog done");
    summarize();
  end
endmodule : timebase_timer_unit_test
`default_nettype wire
